// *** hdl/ddio_pkg.sv ***
/*
  Shared types and constants for the memory I/O cell block: gearing modes,
  margin control bundle, read tracking states, reset values and limits.
  Assumes every user writes ddio_pkg::name; nothing is imported.
*/
`default_nettype none

package ddio_pkg;

  // Output gearing ratios
  typedef enum logic [1:0] {
    GEAR_X1 = 2'h0,
    GEAR_X2 = 2'h1,
    GEAR_X4 = 2'h2,
    GEAR_X7 = 2'h3
  } ddio_gear_t;

  // One margin control channel from the core
  typedef struct packed {
    logic load_n;
    logic step;
    logic dir;
  } ddio_margin_t;

  // Read burst tracking, Gray along idle, wait, burst
  typedef enum logic [1:0] {
    RD_IDLE = 2'b00,
    RD_WAIT = 2'b01,
    RD_BURST = 2'b11
  } ddio_rd_state_t;

  localparam logic [7:0] MARGIN_RST = 8'h00;
  localparam logic [7:0] MARGIN_MAX = 8'hff;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [1:0] WR_PHASE_RST = 2'h0;
  localparam logic [6:0] WORD_RST = 7'h00;
  localparam logic [3:0] LAT_BASE = 4'h2;
  localparam int GROUP_CELLS = 16;
  localparam int MIN_DATA_PINS = 11;
  localparam int MIN_BONDED = 2;
  localparam logic [1:0] AUX_ON = 2'h3;

endpackage

`default_nettype wire

// *** hdl/ddio_top.sv ***
/*
  Output, tristate and strobe control logic of one strobe group of memory
  I/O cells: output gearing, enable registers, write clocks, delay codes
  with margin control, input FIFO pointers and read burst tracking.
  Assumes clk_in is the fast edge clock at memory rate; strobe_clk_in is
  the delayed read strobe from the memory and may stop between bursts;
  all other inputs are synchronous to clk_in.
*/
`timescale 1ns/10ps
`default_nettype none

module ddio_top #(
  parameter bit TOP_EDGE = 1'b0,
  parameter bit FIRST_PAIR = 1'b1,
  parameter int BONDED_PINS = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic strobe_clk_in,
  input wire logic [1:0] gear_mode_in,
  input wire logic [6:0] data_word_in,
  input wire logic mem_write_mode_in,
  input wire logic [1:0] output_enable_in,
  input wire logic double_rate_enable_mode_in,
  input wire logic [7:0] read_delay_code_in,
  input wire logic [7:0] leveling_delay_ctrl_in,
  input wire ddio_pkg::ddio_margin_t read_margin_in,
  input wire ddio_pkg::ddio_margin_t write_margin_in,
  input wire logic pause_in,
  input wire logic [1:0] read_in,
  input wire logic [1:0] read_pulse_select_in,
  input wire logic aux_supply_en_in,
  output logic serial_data_out,
  output logic word_take_out,
  output logic output_enable_out,
  output logic write_strobe_clock_out,
  output logic write_data_clock_out,
  output logic strobe_true_out,
  output logic strobe_comp_out,
  output logic [7:0] delayed_read_strobe_taps_out,
  output logic [7:0] leveling_taps_out,
  output logic read_margin_max_out,
  output logic write_margin_max_out,
  output logic [2:0] fifo_write_pointer_out,
  output logic [2:0] fifo_read_pointer_out,
  output logic read_data_valid_out,
  output logic burst_detected_out,
  output logic group_data_capable_out,
  output logic [1:0] aux_supply_out
);

  // Refuse shapes the logic cannot serve
  if (BONDED_PINS < ddio_pkg::MIN_BONDED ||
      BONDED_PINS > ddio_pkg::GROUP_CELLS)
  begin : g_bad_pins
    $error("bonded pin count outside one strobe group");
  end
  if (TOP_EDGE && FIRST_PAIR)
  begin : g_bad_pair
    $error("top edge has no seven bit pad pair");
  end

  // Bits per word for a gearing mode, after edge limits
  function automatic logic [2:0] word_len(input ddio_pkg::ddio_gear_t m);
    logic [2:0] n;
    n = 3'h1;
    if (!TOP_EDGE)
    begin
      unique case (m)
        ddio_pkg::GEAR_X1: n = 3'h1;
        ddio_pkg::GEAR_X2: n = 3'h2;
        ddio_pkg::GEAR_X4: n = 3'h4;
        ddio_pkg::GEAR_X7: n = FIRST_PAIR ? 3'h7 : 3'h1;
      endcase
    end
    return n;
  endfunction

  // Gray encode of a binary pointer
  function automatic logic [2:0] to_gray(input logic [2:0] b);
    return b ^ (b >> 1);
  endfunction

  // Saturating margin update
  function automatic logic [7:0] margin_next(input logic [7:0] v,
                                             input logic up);
    logic [7:0] r;
    r = v;
    if (up && v != ddio_pkg::MARGIN_MAX)
      r = v + 8'h01;
    else if (!up && v != ddio_pkg::MARGIN_RST)
      r = v - 8'h01;
    return r;
  endfunction

  logic [1:0] wr_phase_ff;
  logic wr_data_rise;
  logic advance;
  logic [2:0] cnt_ff;
  logic [2:0] len_ff;
  logic [6:0] shift_ff;
  logic [1:0] oe_word_ff;
  logic oe_dual_ff;
  logic [7:0] rd_margin_ff;
  logic [7:0] wr_margin_ff;
  logic rd_step_ff;
  logic wr_step_ff;
  logic [2:0] s_bin_ff;
  logic [2:0] wr_sync1_ff;
  logic [2:0] wr_sync2_ff;
  logic [2:0] r_bin_ff;
  logic ptr_differ;
  ddio_pkg::ddio_rd_state_t rd_state_ff;
  logic [3:0] lat_ff;
  logic [8:0] rd_sum;

  // Write clock phase counter; data clock rises one phase (90 deg) later
  assign wr_data_rise = (wr_phase_ff == 2'h0);
  assign advance = mem_write_mode_in ? wr_data_rise : 1'b1;

  // Divide by four; pause freezes the phase so clocks stand still
  // pause holds write side
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      wr_phase_ff <= ddio_pkg::WR_PHASE_RST;
    else if (!pause_in)
      wr_phase_ff <= wr_phase_ff + 2'h1;
  end

  // Write clocks and strobe pins, all from flops
  // strobe and data clocks
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      write_strobe_clock_out <= 1'b0;
      write_data_clock_out <= 1'b0;
      strobe_true_out <= 1'b0;
      strobe_comp_out <= 1'b1;
    end
    else if (!pause_in)
    begin
      write_strobe_clock_out <= wr_phase_ff[1];
      write_data_clock_out <= write_strobe_clock_out;
      strobe_true_out <= mem_write_mode_in & wr_phase_ff[1];
      strobe_comp_out <= ~(mem_write_mode_in & wr_phase_ff[1]);
    end
  end

  // Serializer: load a word when the count runs out, shift one bit a step
  // registered output path
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cnt_ff <= ddio_pkg::CNT_RST;
      len_ff <= 3'h1;
      shift_ff <= ddio_pkg::WORD_RST;
      serial_data_out <= 1'b0;
      word_take_out <= 1'b0;
    end
    else
    begin
      word_take_out <= 1'b0;
      if (advance && cnt_ff == 3'h0)
      begin
        // top edge forced to one bit
        // seven bits only on first pair
        len_ff <= word_len(ddio_pkg::ddio_gear_t'(gear_mode_in));
        cnt_ff <= word_len(ddio_pkg::ddio_gear_t'(gear_mode_in)) - 3'h1;
        serial_data_out <= data_word_in[0];
        shift_ff <= {1'b0, data_word_in[6:1]};
        word_take_out <= 1'b1;
      end
      else if (advance)
      begin
        cnt_ff <= cnt_ff - 3'h1;
        serial_data_out <= shift_ff[0];
        shift_ff <= {1'b0, shift_ff[6:1]};
      end
    end
  end

  // Tristate path: single flop, or two bits taken with each word
  // single-rate enable flop
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      oe_word_ff <= 2'h0;
      oe_dual_ff <= 1'b0;
      output_enable_out <= 1'b0;
    end
    else if (double_rate_enable_mode_in && !TOP_EDGE)
    begin
      if (advance && cnt_ff == 3'h0)
      begin
        oe_word_ff <= output_enable_in;
        oe_dual_ff <= 1'b1;
        output_enable_out <= output_enable_in[0];
      end
      else if (advance && oe_dual_ff)
      begin
        oe_dual_ff <= 1'b0;
        output_enable_out <= oe_word_ff[1];
      end
    end
    else
    begin
      oe_dual_ff <= 1'b0;
      output_enable_out <= output_enable_in[0];
    end
  end

  // Margin channels; a step counts on its rising edge only
  // load, step, direction
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_margin_ff <= ddio_pkg::MARGIN_RST;
      wr_margin_ff <= ddio_pkg::MARGIN_RST;
      rd_step_ff <= 1'b0;
      wr_step_ff <= 1'b0;
    end
    else
    begin
      rd_step_ff <= read_margin_in.step;
      wr_step_ff <= write_margin_in.step;
      if (!read_margin_in.load_n)
        rd_margin_ff <= ddio_pkg::MARGIN_RST;
      else if (read_margin_in.step && !rd_step_ff)
        rd_margin_ff <= margin_next(rd_margin_ff, read_margin_in.dir);
      if (!write_margin_in.load_n)
        wr_margin_ff <= ddio_pkg::MARGIN_RST;
      else if (write_margin_in.step && !wr_step_ff)
        wr_margin_ff <= margin_next(wr_margin_ff, write_margin_in.dir);
    end
  end

  assign rd_sum = {1'b0, read_delay_code_in} + {1'b0, rd_margin_ff};

  // Delay codes and margin flags
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      delayed_read_strobe_taps_out <= 8'h00;
      leveling_taps_out <= 8'h00;
      read_margin_max_out <= 1'b0;
      write_margin_max_out <= 1'b0;
    end
    else
    begin
      delayed_read_strobe_taps_out <= rd_sum[8] ? ddio_pkg::MARGIN_MAX
                                                : rd_sum[7:0];
      if (!pause_in)
        leveling_taps_out <= leveling_delay_ctrl_in + wr_margin_ff;
      read_margin_max_out <= (rd_margin_ff == ddio_pkg::MARGIN_MAX);
      write_margin_max_out <= (wr_margin_ff == ddio_pkg::MARGIN_MAX);
    end
  end

  // Strobe domain write pointer; strobe may stop, so nothing here waits
  // write pointer
  always_ff @(posedge strobe_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_bin_ff <= ddio_pkg::PTR_RST;
      fifo_write_pointer_out <= ddio_pkg::PTR_RST;
    end
    else
    begin
      s_bin_ff <= s_bin_ff + 3'h1;
      fifo_write_pointer_out <= to_gray(s_bin_ff + 3'h1);
    end
  end

  // Two-flop crossing of the Gray pointer into the edge clock domain
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_sync1_ff <= ddio_pkg::PTR_RST;
      wr_sync2_ff <= ddio_pkg::PTR_RST;
    end
    else
    begin
      wr_sync1_ff <= fifo_write_pointer_out;
      wr_sync2_ff <= wr_sync1_ff;
    end
  end

  assign ptr_differ = (wr_sync2_ff != fifo_read_pointer_out);

  // Read pointer chases the synced write pointer one entry a cycle
  // read pointer
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r_bin_ff <= ddio_pkg::PTR_RST;
      fifo_read_pointer_out <= ddio_pkg::PTR_RST;
    end
    else if (ptr_differ)
    begin
      r_bin_ff <= r_bin_ff + 3'h1;
      fifo_read_pointer_out <= to_gray(r_bin_ff + 3'h1);
    end
  end

  // Read tracking: wait for a burst within the selected latency window
  // burst and valid pulses
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_state_ff <= ddio_pkg::RD_IDLE;
      lat_ff <= 4'h0;
      burst_detected_out <= 1'b0;
      read_data_valid_out <= 1'b0;
    end
    else
    begin
      burst_detected_out <= 1'b0;
      read_data_valid_out <= 1'b0;
      unique case (rd_state_ff)
        ddio_pkg::RD_IDLE:
        begin
          if (read_in != 2'h0)
          begin
            rd_state_ff <= ddio_pkg::RD_WAIT;
            lat_ff <= ddio_pkg::LAT_BASE + {2'h0, read_pulse_select_in};
          end
        end
        ddio_pkg::RD_WAIT:
        begin
          if (ptr_differ)
          begin
            rd_state_ff <= ddio_pkg::RD_BURST;
            burst_detected_out <= 1'b1;
            read_data_valid_out <= 1'b1;
          end
          else if (lat_ff == 4'h0)
            rd_state_ff <= ddio_pkg::RD_IDLE;
          else
            lat_ff <= lat_ff - 4'h1;
        end
        ddio_pkg::RD_BURST:
        begin
          // Burst ends once the FIFO is drained
          if (!ptr_differ)
            rd_state_ff <= ddio_pkg::RD_IDLE;
        end
        default:
          rd_state_ff <= ddio_pkg::RD_IDLE;
      endcase
    end
  end

  // Group pin roles; bonding is fixed, so data capability only settles after reset; aux supply follows its enable only when over 11 pins are bonded
  // one unit per group
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      group_data_capable_out <= 1'b0;
      aux_supply_out <= 2'h0;
    end
    else
    begin
      group_data_capable_out <= (BONDED_PINS >= ddio_pkg::MIN_DATA_PINS);
      aux_supply_out <= (BONDED_PINS > ddio_pkg::MIN_DATA_PINS &&
                         aux_supply_en_in) ? ddio_pkg::AUX_ON : 2'h0;
    end
  end

  a_pause_holds: assert property (
    @(posedge clk_in) disable iff (rst_in)
    pause_in ##1 pause_in |->
      $stable(write_strobe_clock_out) && $stable(leveling_taps_out))
    else $error("write side moved during pause");

  a_data_lags_strobe: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !pause_in ##1 !pause_in |->
      write_data_clock_out == $past(write_strobe_clock_out))
    else $error("data clock not one phase behind strobe clock");

  a_read_gray_step: assert property (
    @(posedge clk_in) disable iff (rst_in)
    $changed(fifo_read_pointer_out) |->
      $onehot(fifo_read_pointer_out ^ $past(fifo_read_pointer_out)))
    else $error("read pointer changed more than one bit");

  a_write_gray_step: assert property (
    @(posedge strobe_clk_in) disable iff (rst_in)
    $changed(fifo_write_pointer_out) |->
      $onehot(fifo_write_pointer_out ^ $past(fifo_write_pointer_out)))
    else $error("write pointer changed more than one bit");

  a_read_flag_max: assert property (
    @(posedge clk_in) disable iff (rst_in)
    read_margin_in.load_n && read_margin_in.step && !rd_step_ff &&
    read_margin_in.dir && rd_margin_ff == 8'hfe
      |-> ##2 read_margin_max_out)
    else $error("read flag missing at maximum");

  a_margin_load: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !write_margin_in.load_n |=> wr_margin_ff == 8'h00 ##1
      !write_margin_max_out)
    else $error("write margin not cleared by load");

  a_burst_valid: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_state_ff == ddio_pkg::RD_WAIT && ptr_differ |=>
      burst_detected_out && read_data_valid_out ##1 !burst_detected_out)
    else $error("burst start not flagged for one cycle");

  a_wait_bound: assert property (
    @(posedge clk_in) disable iff (rst_in)
    rd_state_ff == ddio_pkg::RD_IDLE && read_in != 2'h0 |=>
      ##[1:7] rd_state_ff != ddio_pkg::RD_WAIT)
    else $error("read window outlived latency");

  a_sdr_enable: assert property (
    @(posedge clk_in) disable iff (rst_in)
    !double_rate_enable_mode_in |=>
      output_enable_out == $past(output_enable_in[0]))
    else $error("single rate enable not registered");

  a_top_one_bit: assert property (
    @(posedge clk_in) disable iff (rst_in)
    TOP_EDGE |-> len_ff == 3'h1)
    else $error("top edge used wide gearing");

endmodule

`default_nettype wire

// *** tb/ddio_mem_model.sv ***
/*
  Memory side of the strobe group: sends a burst of read strobe edges
  at an 80 ns period when asked, and leaves the strobe low otherwise.
  Assumes the bench raises go_in once per burst with edges_in stable.
*/
`timescale 1ns/10ps
`default_nettype none

module ddio_mem_model (
  input wire logic go_in,
  input wire logic [3:0] edges_in,
  output logic strobe_out
);
  // Strobe stands still between bursts, as a real memory's would
  initial strobe_out = 1'b0;

  // Burst of edges_in rising edges, phase unrelated to the edge clock
  always @(posedge go_in)
  begin
    repeat (edges_in)
    begin
      #3 strobe_out = 1'b1;
      #40 strobe_out = 1'b0;
      #37;
    end
  end
endmodule

`default_nettype wire

// *** tb/ddio_top_bench.sv ***
/*
  Self-checking bench for ddio_top: gearing table, enable register,
  write clocks and pause, margins, FIFO pointers, read tracking, reset.
  Assumes ddio_mem_model supplies the read strobe bursts.
*/
`timescale 1ns/10ps
`default_nettype none

module ddio_top_bench;
  typedef struct packed {
    logic [1:0] gear;
    logic [6:0] word;
    logic [2:0] len;
  } ddio_row_t;

  logic clk_in = 1'b0;
  logic rst_in = 1'b0;
  logic [1:0] gear = 2'h0;
  logic [6:0] word = 7'h00;
  logic wr_mode = 1'b0;
  logic [1:0] oe = 2'h0;
  logic dr_oe = 1'b0;
  logic [7:0] code = 8'h10;
  logic [7:0] lvl = 8'h20;
  ddio_pkg::ddio_margin_t rd_m = 3'h4;
  ddio_pkg::ddio_margin_t wr_m = 3'h4;
  logic pause = 1'b0;
  logic [1:0] rd = 2'h0;
  logic [1:0] sel = 2'h0;
  logic aux_en = 1'b0;
  logic go = 1'b0;
  logic strobe, sdo, take, oe_out, wsc, wdc, s_t, s_c;
  logic rmax, wmax, dv, bd, cap, prev, hit;
  logic [7:0] rtaps, ltaps;
  logic [2:0] wp, rp, rp_q;
  logic [1:0] aux;
  int n_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int ones;
  ddio_row_t rows [5] = '{'{2'h0, 7'h01, 3'h1}, '{2'h1, 7'h02, 3'h2},
    '{2'h2, 7'h0b, 3'h4}, '{2'h3, 7'h4d, 3'h7}, '{2'h2, 7'h74, 3'h4}};

  ddio_mem_model mem (.go_in(go), .edges_in(4'h4), .strobe_out(strobe));

  ddio_top dut (
    .clk_in(clk_in), .rst_in(rst_in), .strobe_clk_in(strobe),
    .gear_mode_in(gear), .data_word_in(word), .mem_write_mode_in(wr_mode),
    .output_enable_in(oe), .double_rate_enable_mode_in(dr_oe),
    .read_delay_code_in(code), .leveling_delay_ctrl_in(lvl),
    .read_margin_in(rd_m), .write_margin_in(wr_m), .pause_in(pause),
    .read_in(rd), .read_pulse_select_in(sel), .aux_supply_en_in(aux_en),
    .serial_data_out(sdo), .word_take_out(take),
    .output_enable_out(oe_out), .write_strobe_clock_out(wsc),
    .write_data_clock_out(wdc), .strobe_true_out(s_t),
    .strobe_comp_out(s_c), .delayed_read_strobe_taps_out(rtaps),
    .leveling_taps_out(ltaps), .read_margin_max_out(rmax),
    .write_margin_max_out(wmax), .fifo_write_pointer_out(wp),
    .fifo_read_pointer_out(rp), .read_data_valid_out(dv),
    .burst_detected_out(bd), .group_data_capable_out(cap),
    .aux_supply_out(aux)
  );

  always #5 clk_in = ~clk_in;

  task automatic check(input string what, input logic [7:0] seen,
    input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // Bounded wait for the next word load
  task automatic wait_take();
    int k;
    k = 0;
    while (take !== 1'b1 && k < 20)
    begin
      tick(1);
      k++;
    end
    check("word take", 8'(take), 8'h01);
  endtask

  // One margin step on both channels; step low between steps
  task automatic step_both(input logic up);
    rd_m.dir = up;
    wr_m.dir = up;
    rd_m.step = 1'b1;
    wr_m.step = 1'b1;
    tick(1);
    rd_m.step = 1'b0;
    wr_m.step = 1'b0;
    tick(1);
  endtask

  // Idle values while reset is held
  task automatic reset_check();
    check("write pointer", 8'(wp), 8'h00);
    check("read pointer", 8'(rp), 8'h00);
    check("enable reset", 8'(oe_out), 8'h00);
    check("serial reset", 8'(sdo), 8'h00);
    check("comp strobe", 8'(s_c), 8'h01);
  endtask

  // Hang guard, tests need about 700 cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // read pointer moves one bit per step
  always @(posedge clk_in)
  begin
    if (!rst_in && $countones(rp ^ rp_q) > 1)
      check("pointer step", 8'(rp), 8'(rp_q));
    rp_q <= rp;
  end

  initial
  begin
    // Reset raised after start so its edge reaches the strobe domain too
    tick(1);
    rst_in = 1'b1;
    tick(1);
    reset_check();
    tick(2);
    rst_in = 1'b0;
    tick(1);
    check("group capable", 8'(cap), 8'h01);
    foreach (rows[i])
    begin
      gear = rows[i].gear;
      word = rows[i].word;
      wait_take();
      tick(1);
      wait_take();
      for (int b = 0; b < rows[i].len; b++)
      begin
        check("serial bit", 8'(sdo), 8'(word[b]));
        tick(1);
      end
    end
    oe = 2'h1;
    tick(1);
    check("enable", 8'(oe_out), 8'h01);
    // double-rate enable: low bit at word load, high bit next step
    dr_oe = 1'b1;
    oe = 2'h2;
    tick(1);
    wait_take();
    check("enable low", 8'(oe_out), 8'h00);
    tick(1);
    check("enable high", 8'(oe_out), 8'h01);
    tick(1);
    check("enable held", 8'(oe_out), 8'h01);
    dr_oe = 1'b0;
    oe = 2'h1;
    aux_en = 1'b1;
    tick(2);
    check("aux supply", 8'(aux), 8'h03);
    aux_en = 1'b0;
    // write clocks, data clock one cycle behind
    wr_mode = 1'b1;
    tick(2);
    prev = wsc;
    ones = 0;
    for (int c = 0; c < 8; c++)
    begin
      tick(1);
      check("data clock", 8'(wdc), 8'(prev));
      check("strobe pair", 8'(s_c), 8'(!s_t));
      ones += int'(wsc);
      prev = wsc;
    end
    check("clock duty", 8'(ones), 8'h04);
    pause = 1'b1;
    tick(2);
    prev = wsc;
    lvl = 8'h30;
    tick(3);
    check("paused clock", 8'(wsc), 8'(prev));
    check("paused level", ltaps, 8'h20);
    pause = 1'b0;
    tick(3);
    check("level resumes", ltaps, 8'h30);
    lvl = 8'h20;
    wr_mode = 1'b0;
    repeat (3) step_both(1'b1);
    tick(2);
    check("read taps", rtaps, 8'h13);
    check("level taps", ltaps, 8'h23);
    rd_m.load_n = 1'b0;
    tick(3);
    check("read load", rtaps, 8'h10);
    rd_m.load_n = 1'b1;
    step_both(1'b0);
    tick(2);
    check("read floor", rtaps, 8'h10);
    check("write down", ltaps, 8'h22);
    repeat (260) step_both(1'b1);
    tick(2);
    check("read flag", 8'(rmax), 8'h01);
    check("write flag", 8'(wmax), 8'h01);
    check("read ceiling", rtaps, 8'hff);
    check("level wrap", ltaps, 8'h1f);
    step_both(1'b0);
    tick(2);
    check("read flag off", 8'(rmax), 8'h00);
    check("write flag off", 8'(wmax), 8'h00);
    // Write load clears the margin, leveling falls back to its input
    wr_m.load_n = 1'b0;
    tick(3);
    check("write load", ltaps, 8'h20);
    wr_m.load_n = 1'b1;
    // read request with no strobe ends silently
    rd = 2'h1;
    tick(1);
    rd = 2'h0;
    hit = 1'b0;
    repeat (10)
    begin
      tick(1);
      hit = hit | dv | bd;
    end
    check("no burst", 8'(hit), 8'h00);
    // read request with a strobe burst
    rd = 2'h2;
    sel = 2'h3;
    go = 1'b1;
    tick(1);
    rd = 2'h0;
    for (int k = 0; k < 12 && dv !== 1'b1; k++)
      tick(1);
    check("data valid", 8'(dv), 8'h01);
    check("burst detect", 8'(bd), 8'h01);
    tick(30);
    check("write pointer", 8'(wp), 8'h06);
    check("pointers meet", 8'(rp), 8'(wp));
    go = 1'b0;
    rst_in = 1'b1;
    tick(1);
    reset_check();
    rst_in = 1'b0;
    tick(2);
    check("capable again", 8'(cap), 8'h01);
    check("pointer after", 8'(rp), 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
